// File: rtl/level_sync.sv
// Two-stage synchroniser for a level from another domain.
`timescale 1ns/1ps
module level_sync
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Level in and out
  input wire logic din,
  output logic dout
);
  logic meta_r;
  logic meta_nxt;
  logic out_r;
  logic out_nxt;

  always_comb
  begin
    meta_nxt = din;
    out_nxt = meta_r;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      meta_r <= 1'h0;
      out_r <= 1'h0;
    end
    else
    begin
      meta_r <= meta_nxt;
      out_r <= out_nxt;
    end
  end

  assign dout = out_r;
endmodule // level_sync

// File: rtl/supply_droop_pkg.sv
// Types for the supply droop reset control block.
package supply_droop_pkg;
  typedef enum logic [1:0] {
    ST_RUN = 2'h1,
    ST_HOLD = 2'h2
  } droop_state_t;
endpackage

// File: rtl/supply_droop_regs.svh
// Constants for the supply droop reset control block.
`ifndef SUPPLY_DROOP_REGS_SVH
`define SUPPLY_DROOP_REGS_SVH
`define CFG_PWR_OFF_BIT 0
`define CFG_RST_OFF_BIT 1
`define CFG_STOP_ON_BIT 2
`define CFG_HI_SEL_BIT 3
`define CFG_WIDTH 4
`define CFG_RESET_VAL 4'h0
`define SYNC_STAGES 2
`endif

// File: rtl/supply_droop_reset_control.sv
// Control logic around the supply comparator: flag, reset hold, reset pin.
//
// Summary of operation
// - Monitoring is active straight out of reset without software help.
// - monitor_power_off low enables comparison; high turns monitoring off.
// - reset_gen_off low with monitoring on requests reset on falling trip.
// - In stop mode the monitor runs only when keep_on_in_stop is set.
// - high_supply_trip_sel picks 5-V thresholds, otherwise 3-V thresholds.
// - Power-on reset returns trip selection to 3-V mode.
// - Selecting 5-V below its rising level enters reset until supply rises.
// - Once triggered, reset holds until supply passes the rising level or monitor_power_off or reset_gen_off is set.
// - External reset pin is driven low while droop reset is active.
// - Flag is read-only: set below falling, clear above rising, else held.
// - Any reset clears the supply_low_flag.
// - The monitor never raises an interrupt request.
// - Monitor stays active in wait mode; its reset ends wait mode.
// - Monitor active in stop mode with resets enabled ends stop mode.
// - The four configuration bits live in config_word_one.
`timescale 1ns/1ps
`include "supply_droop_regs.svh"
module supply_droop_reset_control
  import supply_droop_pkg::*;
(
  // Clock and resets
  input wire logic clk,
  input wire logic rst_n,
  input wire logic porRst_n,
  // Configuration word write port
  input wire logic cfgWrite,
  input wire logic [`CFG_WIDTH-1:0] cfgWdata,
  // Low-power mode indications
  input wire logic stopMode,
  input wire logic waitMode,
  // Comparator indications, asynchronous
  input wire logic belowFalling3v,
  input wire logic aboveRising3v,
  input wire logic belowFalling5v,
  input wire logic aboveRising5v,
  // Trip selection and monitor enable to the analog comparator
  output logic highSupplyTripSel,
  output logic monitorActive,
  // Status and reset outputs
  output logic [`CFG_WIDTH-1:0] configWordOne,
  output logic supplyLowFlag,
  output logic droopResetReq,
  output logic lowPowerWake,
  output logic resetPinOut,
  output logic resetPinOe,
  output logic irqReq
);

  ////////////////////////////////////////////////////////////////////////////
  // Configuration word one.

  logic [`CFG_WIDTH-1:0] cfg_r;
  logic [`CFG_WIDTH-1:0] cfg_nxt;
  logic monPwrOff;
  logic rstGenOff;
  logic keepOnInStop;

  // The whole word resets only on power-on so a droop reset cannot undo a
  // 5-V selection and release early; the other bits clear likewise.
  always_comb
  begin
    cfg_nxt = cfg_r;
    if (cfgWrite)
    begin
      cfg_nxt = cfgWdata;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!porRst_n)
    begin
      cfg_r <= `CFG_RESET_VAL;
    end
    else
    begin
      cfg_r <= cfg_nxt;
    end
  end

  assign monPwrOff = cfg_r[`CFG_PWR_OFF_BIT];
  assign rstGenOff = cfg_r[`CFG_RST_OFF_BIT];
  assign keepOnInStop = cfg_r[`CFG_STOP_ON_BIT];
  assign highSupplyTripSel = cfg_r[`CFG_HI_SEL_BIT];
  assign configWordOne = cfg_r;

  ////////////////////////////////////////////////////////////////////////////
  // Comparator synchronisers.

  logic [3:0] cmpRaw;
  logic [3:0] cmpSync;
  assign cmpRaw = {aboveRising5v, belowFalling5v, aboveRising3v,
    belowFalling3v};

  // Only power-on clears the synchronisers. A system reset raised by the
  // hold must still pass the above-rising indication that releases it.
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_sync
      level_sync u_sync
      (
        .clk(clk),
        .rst_n(porRst_n),
        .din(cmpRaw[gi]),
        .dout(cmpSync[gi])
      );
    end
  endgenerate

  logic belowFall;
  logic aboveRise;
  // Threshold pair follows the trip selection.
  assign belowFall = highSupplyTripSel ? cmpSync[2] : cmpSync[0];
  assign aboveRise = highSupplyTripSel ? cmpSync[3] : cmpSync[1];

  // Off when powered down, or in stop mode without keep-on; wait mode does
  // not stop it.
  assign monitorActive = !monPwrOff
    && (!stopMode || keepOnInStop);

  ////////////////////////////////////////////////////////////////////////////
  // Flag and reset hold.

  logic flag_r;
  logic flag_nxt;
  droop_state_t state_r;
  droop_state_t state_nxt;

  always_comb
  begin
    flag_nxt = flag_r;
    state_nxt = state_r;
    if (monitorActive)
    begin
      if (belowFall)
      begin
        flag_nxt = 1'h1;
      end
      else if (aboveRise)
      begin
        flag_nxt = 1'h0;
      end
    end
    case (state_r)
      ST_RUN:
      begin
        // Not above the rising level covers a fresh 5-V selection too.
        if (monitorActive && !rstGenOff && (belowFall || !aboveRise))
        begin
          state_nxt = ST_HOLD;
        end
      end
      ST_HOLD:
      begin
        if (aboveRise || monPwrOff || rstGenOff)
        begin
          state_nxt = ST_RUN;
        end
      end
      default:
      begin
        state_nxt = ST_RUN;
      end
    endcase
  end

  // The hold state survives the system reset it creates; only power-on
  // clears it, otherwise the reset would release itself.
  always_ff @(posedge clk)
  begin
    if (!rst_n || !porRst_n)
    begin
      flag_r <= 1'h0;
    end
    else
    begin
      flag_r <= flag_nxt;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!porRst_n)
    begin
      state_r <= ST_RUN;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  assign supplyLowFlag = flag_r;
  assign droopResetReq = (state_r == ST_HOLD);
  assign lowPowerWake = droopResetReq
    && (stopMode || waitMode);
  assign resetPinOut = 1'h0;
  assign resetPinOe = droopResetReq;
  assign irqReq = 1'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  sequence s_trip;
    monitorActive && !rstGenOff && belowFall;
  endsequence

  sequence s_release;
    droopResetReq && aboveRise;
  endsequence

  property p_trip;
    @(posedge clk) disable iff (!porRst_n || !rst_n)
    s_trip |=> droopResetReq;
  endproperty
  a_trip: assert property (p_trip)
    else $error("droop reset missed");

  property p_hold;
    @(posedge clk) disable iff (!porRst_n)
    droopResetReq && !aboveRise && !monPwrOff && !rstGenOff
      |=> droopResetReq;
  endproperty
  a_hold: assert property (p_hold)
    else $error("reset released early");

  property p_release;
    @(posedge clk) disable iff (!porRst_n)
    s_release |=> !droopResetReq;
  endproperty
  a_release: assert property (p_release)
    else $error("reset held above rising level");

  // A fresh 5-V selection below its rising level must hold at once.
  property p_fivesel;
    @(posedge clk) disable iff (!porRst_n)
    highSupplyTripSel && monitorActive && !rstGenOff && !aboveRise
      |=> droopResetReq;
  endproperty
  a_fivesel: assert property (p_fivesel)
    else $error("no reset below 5-V rising level");

  property p_gateoff;
    @(posedge clk) disable iff (!porRst_n)
    monPwrOff || rstGenOff |=> !droopResetReq;
  endproperty
  a_gateoff: assert property (p_gateoff)
    else $error("reset while disabled");

  property p_pin;
    @(posedge clk) disable iff (!porRst_n)
    droopResetReq == resetPinOe;
  endproperty
  a_pin: assert property (p_pin)
    else $error("reset pin mismatch");

  property p_flagset;
    @(posedge clk) disable iff (!rst_n || !porRst_n)
    monitorActive && belowFall |=> supplyLowFlag;
  endproperty
  a_flagset: assert property (p_flagset)
    else $error("flag not set");

  property p_flagclr;
    @(posedge clk) disable iff (!rst_n || !porRst_n)
    monitorActive && !belowFall && aboveRise |=> !supplyLowFlag;
  endproperty
  a_flagclr: assert property (p_flagclr)
    else $error("flag not cleared");

  property p_flagkeep;
    @(posedge clk) disable iff (!rst_n || !porRst_n)
    !monitorActive |=> $stable(supplyLowFlag);
  endproperty
  a_flagkeep: assert property (p_flagkeep)
    else $error("flag moved");

  property p_flagrst;
    @(posedge clk)
    !rst_n || !porRst_n |=> !supplyLowFlag;
  endproperty
  a_flagrst: assert property (p_flagrst)
    else $error("flag survived reset");

  property p_cfgpor;
    @(posedge clk)
    !porRst_n
      |=> (configWordOne == `CFG_RESET_VAL) && !highSupplyTripSel;
  endproperty
  a_cfgpor: assert property (p_cfgpor)
    else $error("config kept over power-on");

  property p_sync;
    @(posedge clk) disable iff (!porRst_n)
    $past(porRst_n) && $past(porRst_n, 2)
      |-> cmpSync == $past(cmpRaw, 2);
  endproperty
  a_sync: assert property (p_sync)
    else $error("synchroniser latency wrong");

  property p_stopoff;
    @(posedge clk) disable iff (!porRst_n)
    stopMode && !keepOnInStop |-> !monitorActive;
  endproperty
  a_stopoff: assert property (p_stopoff)
    else $error("active in stop");

  property p_noirq;
    @(posedge clk) !irqReq;
  endproperty
  a_noirq: assert property (p_noirq)
    else $error("interrupt raised");

  property p_wake;
    @(posedge clk) disable iff (!porRst_n)
    droopResetReq && waitMode |-> lowPowerWake;
  endproperty
  a_wake: assert property (p_wake)
    else $error("no wake");

  property p_wakestop;
    @(posedge clk) disable iff (!porRst_n || !rst_n)
    s_trip ##1 stopMode |-> lowPowerWake;
  endproperty
  a_wakestop: assert property (p_wakestop)
    else $error("no wake from stop");
endmodule // supply_droop_reset_control

// File: tb/supply_comparator_model.sv
// Behavioural model of the analog supply comparators.
`timescale 1ns/1ps
module supply_comparator_model
#(
  parameter int FALL3 = 2600,
  parameter int RISE3 = 2700,
  parameter int FALL5 = 4200,
  parameter int RISE5 = 4300
)
(
  // Supply in millivolts
  input wire logic [15:0] supplyMv,
  // Comparator levels
  output logic belowFalling3v,
  output logic aboveRising3v,
  output logic belowFalling5v,
  output logic aboveRising5v
);
  // Both ranges answer at once, so a range change shows no gap.
  assign belowFalling3v = supplyMv < FALL3;
  assign aboveRising3v = supplyMv > RISE3;
  assign belowFalling5v = supplyMv < FALL5;
  assign aboveRising5v = supplyMv > RISE5;
endmodule // supply_comparator_model

// File: tb/tb_supply_droop_reset_control.sv
// Self-checking bench for the supply droop reset control block.
`timescale 1ns/1ps
module tb_supply_droop_reset_control;
  localparam int F3 = 2600, R3 = 2700, F5 = 4200, R5 = 4300;
  logic clk = 1'b0, rst_n = 1'b0, porRst_n = 1'b0, cfgWrite = 1'b0;
  logic stopMode = 1'b0, waitMode = 1'b0;
  logic [3:0] cfgWdata = 4'h0, cfgOut;
  logic [15:0] supplyMv = 16'hCE4;
  logic bf3, ar3, bf5, ar5, sel, act, flag, req, wake, pinOut, pinOe, irq;
  int numErrors = 0, checkCount = 0, seed = 88;
  int cfgM = 0, flagM = 0, holdM = 0;
  int mvs[3] = '{2500, 3300, 4500};
  always #4 clk = ~clk;
  supply_comparator_model #(.FALL3(F3), .RISE3(R3), .FALL5(F5),
    .RISE5(R5)) cmp (.supplyMv(supplyMv), .belowFalling3v(bf3),
    .aboveRising3v(ar3), .belowFalling5v(bf5), .aboveRising5v(ar5));
  supply_droop_reset_control dut (.clk(clk), .rst_n(rst_n),
    .porRst_n(porRst_n), .cfgWrite(cfgWrite), .cfgWdata(cfgWdata),
    .stopMode(stopMode), .waitMode(waitMode), .belowFalling3v(bf3),
    .aboveRising3v(ar3), .belowFalling5v(bf5), .aboveRising5v(ar5),
    .highSupplyTripSel(sel), .monitorActive(act), .configWordOne(cfgOut),
    .supplyLowFlag(flag), .droopResetReq(req), .lowPowerWake(wake),
    .resetPinOut(pinOut), .resetPinOe(pinOe), .irqReq(irq));
  task automatic chk(input logic [3:0] got, input int exp);
    checkCount++;
    if (got !== 4'(exp))
    begin
      numErrors++;
      $display("Error at %0t: got %h expected %h", $time, got, 4'(exp));
    end
  endtask
  task automatic completeRun();
    if (numErrors == 0 && checkCount > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Transients while a change ripples through are not modelled, so the
  // comparison waits until the synchronisers have settled.
  task automatic put(input int mv, input int c, input logic s, input logic w);
    int lo, hi, a;
    if (c != cfgM)
    begin
      @(posedge clk);
      #1 cfgWrite = 1'b1;
      cfgWdata = 4'(c);
      @(posedge clk);
      #1 cfgWrite = 1'b0;
    end
    cfgM = c;
    supplyMv = 16'(mv);
    stopMode = s;
    waitMode = w;
    lo = c[3] ? F5 : F3;
    hi = c[3] ? R5 : R3;
    a = !c[0] && (!s || c[2]);
    if (a && mv < lo)
      flagM = 1;
    else if (a && mv > hi)
      flagM = 0;
    if (mv > hi || c[0] || c[1])
      holdM = 0;
    else if (a)
      holdM = 1;
    repeat (4) @(posedge clk);
    #1;
    chk(cfgOut, c);
    chk(sel, c[3]);
    chk(act, a);
    chk(flag, flagM);
    chk(req, holdM);
    chk(pinOe, holdM);
    chk(pinOut, 0);
    chk(irq, 0);
    chk(wake, holdM && (s || w));
  endtask
  initial
  begin
    #200000;
    numErrors++;
    completeRun();
  end
  initial
  begin
    repeat (5) @(posedge clk);
    #1 rst_n = 1'b1;
    porRst_n = 1'b1;
    put(3300, 0, 0, 0);
    put(2500, 0, 0, 0);
    put(2650, 0, 0, 1);
    put(3300, 0, 0, 1);
    put(2500, 4, 1, 0);
    put(3300, 4, 1, 0);
    put(2500, 0, 1, 0);
    put(2500, 1, 0, 0);
    put(3300, 2, 0, 0);
    supplyMv = 16'h9C4;
    repeat (2) @(posedge clk);
    #1 chk(flag, 0);
    @(posedge clk);
    #1 chk(flag, 1);
    flagM = 1;
    put(2650, 2, 0, 0);
    @(posedge clk);
    #1 rst_n = 1'b0;
    repeat (3) @(posedge clk);
    #1 chk(flag, 0);
    rst_n = 1'b1;
    flagM = 0;
    put(2650, 2, 0, 0);
    put(3300, 8, 0, 0);
    put(4500, 8, 0, 0);
    @(posedge clk);
    #1 porRst_n = 1'b0;
    rst_n = 1'b0;
    repeat (3) @(posedge clk);
    #1 porRst_n = 1'b1;
    rst_n = 1'b1;
    cfgM = 0;
    flagM = 0;
    holdM = 0;
    put(4500, 0, 0, 0);
    repeat (40)
      put(mvs[$unsigned($random(seed)) % 3], $random(seed) & 15, 1'b0,
        1'($random(seed) & 1));
    completeRun();
  end
endmodule // tb_supply_droop_reset_control
